// ==== nvsram_host_params.svh ====
// Pin timing constants and cycle counts for the nvSRAM host controller
`ifndef NVSRAM_HOST_PARAMS_SVH
`define NVSRAM_HOST_PARAMS_SVH

`define NV_CLK_MHZ 50
`define NV_ADDR_W 11
`define NV_DATA_W 8

// Times in their printed units
`define NV_READ_CYCLE_NS 45
`define NV_WRITE_PULSE_NS 35
`define NV_DATA_SETUP_NS 20
`define NV_INIT_HOLD_NS 25
`define NV_RECALL_US 20
`define NV_STORE_MS 10
`define NV_RESTORE_US 650

// Least times round up to whole cycles
`define NV_CEIL_CYC(ns) ((((ns) * `NV_CLK_MHZ) + 999) / 1000)
`define NV_MAX(a, b) (((a) > (b)) ? (a) : (b))

`define NV_READ_CYC `NV_CEIL_CYC(`NV_READ_CYCLE_NS)
`define NV_WRITE_CYC `NV_MAX(`NV_CEIL_CYC(`NV_WRITE_PULSE_NS), `NV_CEIL_CYC(`NV_DATA_SETUP_NS))
`define NV_INIT_CYC `NV_CEIL_CYC(`NV_INIT_HOLD_NS)
`define NV_RECALL_CYC (`NV_RECALL_US * `NV_CLK_MHZ)
`define NV_STORE_CYC (`NV_STORE_MS * 1000 * `NV_CLK_MHZ)
`define NV_RESTORE_CYC (`NV_RESTORE_US * `NV_CLK_MHZ)
`define NV_SYNC_LAT 3
`define NV_CNT_W 20

`endif

// ==== nvsram_host_pkg.sv ====
// Types shared by the nvSRAM host controller
`default_nettype none
`include "nvsram_host_params.svh"

package nvsram_host_pkg;

  typedef enum logic [1:0] {
    OP_READ = 2'b00,
    OP_WRITE = 2'b01,
    OP_STORE = 2'b10,
    OP_RECALL = 2'b11
  } nv_op_t;

  typedef struct packed {
    nv_op_t op;
    logic [`NV_ADDR_W-1:0] addr;
    logic [`NV_DATA_W-1:0] wdata;
  } nv_cmd_t;

  typedef struct packed {
    logic chip_select_n;
    logic output_drive_n;
    logic write_strobe_n;
    logic nonvolatile_select_n;
  } nv_ctrl_t;

  typedef enum logic [3:0] {
    ST_PWR_OFF = 4'h0,
    ST_RESTORE = 4'h1,
    ST_IDLE = 4'h2,
    ST_RD = 4'h3,
    ST_WR_ADDR = 4'h4,
    ST_WR = 4'h5,
    ST_WR_END = 4'h6,
    ST_NV_SETUP = 4'h7,
    ST_NV_INIT = 4'h8,
    ST_NV_WAIT = 4'h9,
    ST_GAP = 4'ha
  } host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [`NV_CNT_W-1:0] cnt;
    nv_op_t op;
    logic [`NV_ADDR_W-1:0] addr;
    logic [`NV_DATA_W-1:0] wdata;
    logic [`NV_DATA_W-1:0] rdata;
    logic rsp_valid;
    nv_ctrl_t ctrl;
    logic data_oe;
    logic [2:0] good_sync;
    logic good;
    logic [2:0][`NV_DATA_W-1:0] data_sync;
  } host_regs_t;

endpackage : nvsram_host_pkg
`default_nettype wire

// ==== nvsram_host.sv ====
// Host controller driving the pins of an asynchronous nonvolatile SRAM
`timescale 1ns/1ps
`default_nettype none
`include "nvsram_host_params.svh"

// Notes on behaviour
// - Host holds address stable through write
// - Byte latched at write end, data set up
// - Host keeps output drive high while writing
// - Host makes strobe (store) or output drive (recall) fall last
// - Host avoids write state at restore end
// - Initiating state held at least 25 ns
module nvsram_host #(
  parameter int STORE_CYC = `NV_STORE_CYC,
  parameter int RESTORE_CYC = `NV_RESTORE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic supply_good,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire nvsram_host_pkg::nv_cmd_t cmd,
  output logic rsp_valid,
  output logic [`NV_DATA_W-1:0] rsp_data,
  output nvsram_host_pkg::nv_ctrl_t ctrl,
  output logic [`NV_ADDR_W-1:0] addr_in,
  input wire logic [`NV_DATA_W-1:0] data_in,
  output logic [`NV_DATA_W-1:0] data_out,
  output logic data_oe
);

  localparam nvsram_host_pkg::nv_ctrl_t CTRL_IDLE = 4'hf;

  nvsram_host_pkg::host_regs_t r;
  nvsram_host_pkg::host_regs_t next_r;

  function automatic logic [`NV_CNT_W-1:0] load(input int cycles);
    load = `NV_CNT_W'(cycles - 1);
  endfunction : load

  always_comb begin
    next_r = r;
    next_r.rsp_valid = 1'b0;
    next_r.good_sync = {r.good_sync[1:0], supply_good};
    next_r.data_sync = {r.data_sync[1:0], data_in};
    // Level counts once the second and third stage agree
    if (r.good_sync[1] == r.good_sync[2]) begin
      next_r.good = r.good_sync[2];
    end
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - `NV_CNT_W'(1);
    end
    case (r.st)
      nvsram_host_pkg::ST_PWR_OFF: begin
        if (r.good) begin
          next_r.st = nvsram_host_pkg::ST_RESTORE;
          next_r.cnt = load(RESTORE_CYC);
        end
      end
      nvsram_host_pkg::ST_RESTORE: begin
        if (r.cnt == '0) begin
          next_r.st = nvsram_host_pkg::ST_IDLE;
        end
      end
      nvsram_host_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          next_r.op = cmd.op;
          next_r.addr = cmd.addr;
          next_r.wdata = cmd.wdata;
          case (cmd.op)
            nvsram_host_pkg::OP_READ: begin
              next_r.ctrl.chip_select_n = 1'b0;
              next_r.ctrl.output_drive_n = 1'b0;
              next_r.cnt = load(`NV_READ_CYC + `NV_SYNC_LAT);
              next_r.st = nvsram_host_pkg::ST_RD;
            end
            nvsram_host_pkg::OP_WRITE: begin
              next_r.data_oe = 1'b1;
              next_r.st = nvsram_host_pkg::ST_WR_ADDR;
            end
            default: begin
              // Setup state is a no-operation pin pattern
              next_r.ctrl.chip_select_n = 1'b0;
              next_r.ctrl.nonvolatile_select_n = 1'b0;
              next_r.st = nvsram_host_pkg::ST_NV_SETUP;
            end
          endcase
        end
      end
      nvsram_host_pkg::ST_RD: begin
        // sample after access plus synchroniser delay
        if (r.cnt == '0) begin
          next_r.rdata = r.data_sync[2];
          next_r.rsp_valid = 1'b1;
          next_r.ctrl = CTRL_IDLE;
          next_r.st = nvsram_host_pkg::ST_GAP;
        end
      end
      nvsram_host_pkg::ST_WR_ADDR: begin
        // write with output drive kept high
        next_r.ctrl.chip_select_n = 1'b0;
        next_r.ctrl.write_strobe_n = 1'b0;
        next_r.cnt = load(`NV_WRITE_CYC);
        next_r.st = nvsram_host_pkg::ST_WR;
      end
      nvsram_host_pkg::ST_WR: begin
        // strobe rises with data still driven
        if (r.cnt == '0) begin
          next_r.ctrl = CTRL_IDLE;
          next_r.st = nvsram_host_pkg::ST_WR_END;
        end
      end
      nvsram_host_pkg::ST_WR_END: begin
        next_r.data_oe = 1'b0;
        next_r.rsp_valid = 1'b1;
        next_r.st = nvsram_host_pkg::ST_GAP;
      end
      nvsram_host_pkg::ST_NV_SETUP: begin
        if (r.op == nvsram_host_pkg::OP_STORE) begin
          next_r.ctrl.write_strobe_n = 1'b0;
        end else begin
          // output drive is the last recall pin
          next_r.ctrl.output_drive_n = 1'b0;
        end
        next_r.cnt = load(`NV_INIT_CYC);
        next_r.st = nvsram_host_pkg::ST_NV_INIT;
      end
      nvsram_host_pkg::ST_NV_INIT: begin
        if (r.cnt == '0) begin
          next_r.ctrl = CTRL_IDLE;
          if (r.op == nvsram_host_pkg::OP_STORE) begin
            next_r.cnt = load(STORE_CYC);
          end else begin
            next_r.cnt = load(`NV_RECALL_CYC);
          end
          next_r.st = nvsram_host_pkg::ST_NV_WAIT;
        end
      end
      nvsram_host_pkg::ST_NV_WAIT: begin
        if (r.cnt == '0) begin
          next_r.rsp_valid = 1'b1;
          next_r.st = nvsram_host_pkg::ST_IDLE;
        end
      end
      nvsram_host_pkg::ST_GAP: begin
        next_r.st = nvsram_host_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = nvsram_host_pkg::ST_PWR_OFF;
      end
    endcase
    // supply loss drops everything and waits for power
    if (!r.good) begin
      next_r.st = nvsram_host_pkg::ST_PWR_OFF;
      next_r.ctrl = CTRL_IDLE;
      next_r.data_oe = 1'b0;
      next_r.rsp_valid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.ctrl <= CTRL_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Accepted only when idle; refused during power-up and operations
  assign cmd_ready = (r.st == nvsram_host_pkg::ST_IDLE) && r.good;
  assign rsp_valid = r.rsp_valid;
  assign rsp_data = r.rdata;
  assign ctrl = r.ctrl;
  assign addr_in = r.addr;
  assign data_out = r.wdata;
  assign data_oe = r.data_oe;

  wire logic wr_cond = !ctrl.chip_select_n && !ctrl.write_strobe_n && ctrl.nonvolatile_select_n;
  wire logic st_cond = !ctrl.chip_select_n && !ctrl.write_strobe_n
                       && !ctrl.nonvolatile_select_n && ctrl.output_drive_n;
  wire logic rc_cond = !ctrl.chip_select_n && !ctrl.output_drive_n
                       && !ctrl.nonvolatile_select_n && ctrl.write_strobe_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence store_entry;
    $rose(st_cond);
  endsequence

  sequence recall_entry;
    $rose(rc_cond);
  endsequence

  sequence write_end;
    $rose(ctrl.write_strobe_n) && $past(wr_cond);
  endsequence

  addr_stable_a: assert property (wr_cond && $past(wr_cond) |-> $stable(addr_in))
    else $error("address moved during write");
  write_setup_a: assert property (write_end |-> $past(data_oe, 1) && $past(data_oe, 2)
                                  && $past(data_oe, 3) && $stable(data_out))
    else $error("write data not set up before strobe rise");
  write_hold_a: assert property (write_end |-> data_oe)
    else $error("write data dropped at strobe rise");
  drive_high_a: assert property (wr_cond |-> ctrl.output_drive_n)
    else $error("output drive low during write");
  store_order_a: assert property (store_entry |-> $past(!ctrl.chip_select_n
                                  && !ctrl.nonvolatile_select_n && ctrl.output_drive_n))
    else $error("store entered without strobe falling last");
  store_hold_a: assert property (store_entry |-> st_cond [*2])
    else $error("store state held too short");
  recall_hold_a: assert property (recall_entry |-> rc_cond [*2])
    else $error("recall state held too short");
  restore_we_a: assert property (r.st == nvsram_host_pkg::ST_RESTORE && r.cnt == '0
                                 |=> !wr_cond)
    else $error("write state at end of power-up recall");
  read_resp_a: assert property (rsp_valid && r.op == nvsram_host_pkg::OP_READ
                                |-> $past(!ctrl.chip_select_n && !ctrl.output_drive_n))
    else $error("read answer without read pin state");

endmodule : nvsram_host
`default_nettype wire

// ==== nvsram_dev_model.sv ====
// Behavioural nonvolatile SRAM device answering the host controller's pins
`timescale 1ns/1ps
`default_nettype none

module nvsram_dev_model (
  input wire nvsram_host_pkg::nv_ctrl_t ctrl,
  input wire logic [10:0] addr_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic supply_good,
  output logic [7:0] data_in
);
  logic [7:0] mem [2048];
  logic [7:0] nv [2048];
  logic busy = 1'b0;
  logic flip = 1'b0;
  logic rd, st, rc, wr;
  logic st_p = 1'b0;
  logic rc_p = 1'b0;
  logic wr_p = 1'b0;

  initial foreach (nv[i]) nv[i] = 8'(i) ^ 8'h3c;
  // Undriven lines wander, so a stale byte never passes
  always #7 flip = ~flip;

  assign rd = !ctrl.chip_select_n && !ctrl.output_drive_n && ctrl.write_strobe_n
              && ctrl.nonvolatile_select_n;
  assign st = !ctrl.chip_select_n && !ctrl.write_strobe_n && !ctrl.nonvolatile_select_n
              && ctrl.output_drive_n;
  assign rc = !ctrl.chip_select_n && !ctrl.output_drive_n && !ctrl.nonvolatile_select_n
              && ctrl.write_strobe_n;
  assign wr = !ctrl.chip_select_n && !ctrl.write_strobe_n && ctrl.nonvolatile_select_n;

  // drive only on a clean read
  always_comb data_in = data_oe ? data_out : (rd && !busy) ? mem[addr_in] : 8'h5a ^ {8{flip}};

  // Blocking here is how inputs are ignored during an operation
  always @(ctrl or supply_good) begin
    if (wr_p && !wr) mem[addr_in] = data_in;
    if (st && !st_p && supply_good) begin
      busy = 1'b1;
      fork
        #300;
        wait (!supply_good);
      join_any
      disable fork;
      if (supply_good) begin
        foreach (nv[i]) nv[i] = 8'hff;
        foreach (nv[i]) nv[i] = mem[i];
      end
      busy = 1'b0;
    end
    // recall on the last pin arriving
    if (rc && !rc_p) begin
      busy = 1'b1;
      foreach (mem[i]) mem[i] = 8'h00;
      #5000;
      foreach (mem[i]) mem[i] = nv[i];
      busy = 1'b0;
    end
    // pins seen afresh only after the operation
    st_p = st;
    rc_p = rc;
    wr_p = wr;
  end

  always @(posedge supply_good) begin
    busy = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    #150;
    foreach (mem[i]) mem[i] = nv[i];
    busy = 1'b0;
  end
endmodule : nvsram_dev_model

`default_nettype wire

// ==== nvsram_host_tb_top.sv ====
// Self-checking bench for the nvSRAM host controller against a device model
`timescale 1ns/1ps
`default_nettype none

module nvsram_host_tb_top;
  logic clk, rstn, supply_good, cmd_valid, cmd_ready, rsp_valid, data_oe;
  nvsram_host_pkg::nv_cmd_t cmd;
  nvsram_host_pkg::nv_ctrl_t ctrl;
  logic [7:0] rsp_data, data_in, data_out, rd;
  logic [10:0] addr_in;
  int error_cnt = 0;
  int tests_run = 0;
  int ref_mem [2048];
  int ref_nv [2048];
  int a [8];

  nvsram_host #(.STORE_CYC(20), .RESTORE_CYC(10)) dut_u (
    .clk(clk), .rstn(rstn), .supply_good(supply_good), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .ctrl(ctrl), .addr_in(addr_in), .data_in(data_in), .data_out(data_out), .data_oe(data_oe)
  );
  nvsram_dev_model dev_u (
    .ctrl(ctrl), .addr_in(addr_in), .data_out(data_out), .data_oe(data_oe),
    .supply_good(supply_good), .data_in(data_in)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input logic exp, input logic got);
    check_byte({7'h00, exp}, {7'h00, got});
  endtask : check_bit

  task automatic give_verdict();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Request held until the edge that sees ready high
  task automatic issue(input nvsram_host_pkg::nv_op_t op, input int ad, input int wd);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= '{op, 11'(ad), 8'(wd)};
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 2000);
    cmd_valid <= 1'b0;
  endtask : issue

  task automatic do_cmd(input nvsram_host_pkg::nv_op_t op, input int ad, input int wd);
    int n;
    n = 0;
    issue(op, ad, wd);
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    check_bit(1'b1, rsp_valid);
    rd = rsp_data;
  endtask : do_cmd

  task automatic wr(input int ad, input int wd);
    do_cmd(nvsram_host_pkg::OP_WRITE, ad, wd);
    ref_mem[ad] = wd & 255;
  endtask : wr

  task automatic rd_chk(input int ad);
    do_cmd(nvsram_host_pkg::OP_READ, ad, 0);
    check_byte(8'(ref_mem[ad]), rd);
  endtask : rd_chk

  initial begin
    rstn = 1'b0;
    supply_good = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    void'($urandom(78));
    foreach (ref_nv[i]) ref_nv[i] = (i & 255) ^ 8'h3c;
    ref_mem = ref_nv;
    foreach (a[i]) a[i] = $urandom % 2048;
    a[0] = 0;
    a[1] = 2047;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    supply_good <= 1'b1;
    foreach (a[i]) rd_chk(a[i]);
    $display("test powerup_recall done");
    foreach (a[i]) wr(a[i], $urandom);
    for (int i = 7; i >= 0; i--) rd_chk(a[i]);
    $display("test write_read done");
    do_cmd(nvsram_host_pkg::OP_STORE, 0, 0);
    ref_nv = ref_mem;
    foreach (a[i]) wr(a[i], $urandom);
    foreach (a[i]) rd_chk(a[i]);
    for (int k = 0; k < 2; k++) begin
      do_cmd(nvsram_host_pkg::OP_RECALL, 0, 0);
      ref_mem = ref_nv;
      foreach (a[i]) rd_chk(a[i]);
    end
    $display("test store_recall done");
    foreach (a[i]) wr(a[i], $urandom);
    issue(nvsram_host_pkg::OP_STORE, 0, 0);
    repeat (5) @(posedge clk);
    supply_good <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      check_bit(1'b0, rsp_valid);
      check_bit(1'b0, cmd_ready);
    end
    supply_good <= 1'b1;
    // Aborted store leaves the older image to come back
    ref_mem = ref_nv;
    foreach (a[i]) rd_chk(a[i]);
    $display("test supply_abort done");
    give_verdict();
  end

  // Run needs about 55 us; this cuts a hang well after that
  initial begin
    #1000000;
    error_cnt++;
    give_verdict();
  end
endmodule : nvsram_host_tb_top

`default_nettype wire
